// ---- shared/tprb_pkg.sv ----
// register map, field positions and reset values of the pll register bank
// assumes an 11-bit byte-wide reconfiguration address space
package tprb_pkg;
	localparam int          ADDR_W          = 11;
	localparam int          DATA_W          = 8;
	localparam logic [10:0] OFS_ARB         = 11'h000;
	localparam logic [10:0] OFS_CAL         = 11'h100;
	localparam logic [10:0] OFS_ID0         = 11'h400;
	localparam logic [10:0] OFS_ID1         = 11'h401;
	localparam logic [10:0] OFS_ID2         = 11'h402;
	localparam logic [10:0] OFS_ID3         = 11'h403;
	localparam logic [10:0] OFS_STAT_EN     = 11'h404;
	localparam logic [10:0] OFS_CTRL_EN     = 11'h405;
	localparam logic [10:0] OFS_MCG_EN      = 11'h410;
	localparam logic [10:0] OFS_STATUS      = 11'h480;
	localparam logic [10:0] OFS_PDN         = 11'h4E0;
	localparam int          BIT_ARB_OWNER   = 0;
	localparam int          BIT_CAL_DONE    = 1;
	localparam int          BIT_TUNE_EN     = 0;
	localparam int          BIT_RECFG_REQ   = 1;
	localparam int          BIT_PRESENT     = 0;
	localparam int          BIT_LOCKED      = 0;
	localparam int          BIT_CAL_BUSY    = 1;
	localparam int          BIT_BUS_BUSY    = 2;
	localparam int          BIT_PDN_VAL     = 0;
	localparam int          BIT_PDN_OVR     = 1;
	localparam logic        RST_ARB_OWNER   = 1'b0;
	localparam logic        RST_TUNE_EN     = 1'b0;
	localparam logic        RST_RECFG_REQ   = 1'b0;
	localparam logic        RST_PDN_VAL     = 1'b0;
	localparam logic        RST_PDN_OVR     = 1'b0;
	localparam logic [7:0]  RST_RDATA       = 8'h00;
endpackage : tprb_pkg

// ---- shared/tprb_ctl_if.sv ----
// write strobes and data travelling from the bus front end to the pll control module, and its control bits back
// assumes both ends share the register clock
`timescale 1ns/1ps
interface tprb_ctl_if;
	logic wr_arb;
	logic wr_cal;
	logic wr_pdn;
	logic [7:0] wdata;
	logic arb_owner;
	logic tune_en;
	logic recfg_req;
	logic pdn_val;
	logic pdn_ovr;
	modport front (output wr_arb, output wr_cal, output wr_pdn, output wdata,
		input arb_owner, input tune_en, input recfg_req, input pdn_val, input pdn_ovr);
	modport ctl (input wr_arb, input wr_cal, input wr_pdn, input wdata,
		output arb_owner, output tune_en, output recfg_req, output pdn_val, output pdn_ovr);
endinterface : tprb_ctl_if

// ---- logic/tprb_decode.sv ----
// write strobe decoder for the writable registers
// assumes the address and write strobe are synchronous to ref_clk_i
`timescale 1ns/1ps
module tprb_decode
	import tprb_pkg::*;
(
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic              write_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	tprb_ctl_if.front              ctl
);
	always_comb
	begin
		ctl.wr_arb = write_i && (addr_i == OFS_ARB);
		ctl.wr_cal = write_i && (addr_i == OFS_CAL);
		ctl.wr_pdn = write_i && (addr_i == OFS_PDN);
		ctl.wdata  = wdata_i;
	end
endmodule : tprb_decode

// ---- logic/tprb_ctl.sv ----
// writable control bits of the bank
// assumes write strobes already qualified with the clock enable
`timescale 1ns/1ps
module tprb_ctl
	import tprb_pkg::*;
(
	input  wire logic ref_clk_i,
	input  wire logic reset_n_i,
	input  wire logic clk_en_i,
	tprb_ctl_if.ctl   ctl
);
	typedef struct packed {
		logic arb_owner;
		logic tune_en;
		logic recfg_req;
		logic pdn_val;
		logic pdn_ovr;
	} tprb_ctl_t;

	tprb_ctl_t st_reg;
	tprb_ctl_t st_next;

	always_comb
	begin
		st_next = st_reg;
		if (ctl.wr_arb)
			st_next.arb_owner = ctl.wdata[BIT_ARB_OWNER];
		if (ctl.wr_cal)
		begin
			st_next.tune_en   = ctl.wdata[BIT_TUNE_EN];
			st_next.recfg_req = ctl.wdata[BIT_RECFG_REQ];
		end
		if (ctl.wr_pdn)
		begin
			st_next.pdn_val = ctl.wdata[BIT_PDN_VAL];
			st_next.pdn_ovr = ctl.wdata[BIT_PDN_OVR];
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			st_reg <= '{RST_ARB_OWNER, RST_TUNE_EN, RST_RECFG_REQ, RST_PDN_VAL, RST_PDN_OVR};
		else if (clk_en_i)
			st_reg <= st_next;
	end

	assign ctl.arb_owner = st_reg.arb_owner;
	assign ctl.tune_en   = st_reg.tune_en;
	assign ctl.recfg_req = st_reg.recfg_req;
	assign ctl.pdn_val   = st_reg.pdn_val;
	assign ctl.pdn_ovr   = st_reg.pdn_ovr;
endmodule : tprb_ctl

// ---- logic/tprb_bank.sv ----
// top of the transmit pll register bank, reached over the reconfiguration port
// assumes a single-cycle write strobe and a read strobe answered one cycle later
// Function
// - arbitration bit: 0 gives bus to user, 1 to calibration engine
// - calibration-done bit reads as inverse of calibration busy
// - tuning enable bit switches pll calibration on or off
// - reconfiguration request bit asks engine for reconfiguration mode
// - 32-bit instance identifier readable as four bytes, low byte first
// - capability bit shows status registers present
// - capability bit shows control registers present
// - capability bit shows master clock generation block enabled
// - status bit reads 1 while pll is locked
// - status bit reads 1 while pll is being calibrated
// - bus-busy bit reads 1 while calibration engine owns bus
// - powerdown register bit drives pll powerdown when override set
// - override bit selects powerdown from register or from input port
// - bank reachable only through the reconfiguration port
`timescale 1ns/1ps
module tprb_bank
	import tprb_pkg::*;
#(
	parameter logic [31:0] INSTANCE_ID     = 32'h0000_0001, // arbitrary value
	parameter logic        STATUS_REGS_EN  = 1'b1,
	parameter logic        CONTROL_REGS_EN = 1'b1,
	parameter logic        MCGB_EN         = 1'b0
)
(
	input  wire logic                     ref_clk_i,
	input  wire logic                     reset_n_i,
	input  wire logic                     clk_en_i,
	input  wire logic [tprb_pkg::ADDR_W-1:0] addr_i,
	input  wire logic                     write_i,
	input  wire logic                     read_i,
	input  wire logic [tprb_pkg::DATA_W-1:0] wdata_i,
	output logic      [tprb_pkg::DATA_W-1:0] rdata_o,
	output logic                          rvalid_o,
	input  wire logic                     cal_busy_i,
	input  wire logic                     engine_owns_i,
	input  wire logic                     pll_locked_i,
	input  wire logic                     pdn_port_i,
	output logic                          engine_req_o,
	output logic                          tune_enable_o,
	output logic                          recfg_req_o,
	output logic                          pll_powerdown_o
);
	import tprb_pkg::*;

	typedef struct packed {
		logic [7:0] rdata;
		logic       rvalid;
		logic       engine_req;
		logic       tune_en;
		logic       recfg_req;
		logic       pdn;
	} tprb_top_t;

	tprb_top_t  st_reg;
	tprb_top_t  st_next;
	logic [7:0] wdata_q;
	logic       wr_q;
	logic       rd_q;

	tprb_ctl_if cif ();

	////////////////////////////////////////////////////////////////////////////
	// write path: everything writable travels only over this port
	assign wr_q    = write_i && clk_en_i;
	assign rd_q    = read_i && clk_en_i;
	assign wdata_q = wdata_i;

	tprb_decode u_decode (
		.addr_i  (addr_i),
		.write_i (wr_q),
		.wdata_i (wdata_q),
		.ctl     (cif.front)
	);

	tprb_ctl u_ctl (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.clk_en_i  (clk_en_i),
		.ctl       (cif.ctl)
	);

	////////////////////////////////////////////////////////////////////////////
	// read mux; unmapped offsets read zero, unlisted bits read zero so that a
	// read-modify-write by the master puts back what it found
	function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a);
		logic [7:0] d;
		d = 8'h00;
		unique case (a)
			OFS_ARB:
			begin
				d[BIT_ARB_OWNER] = cif.arb_owner;
				d[BIT_CAL_DONE]  = ~cal_busy_i;
			end
			OFS_CAL:
			begin
				d[BIT_TUNE_EN]   = cif.tune_en;
				d[BIT_RECFG_REQ] = cif.recfg_req;
			end
			OFS_ID0:     d = INSTANCE_ID[7:0];
			OFS_ID1:     d = INSTANCE_ID[15:8];
			OFS_ID2:     d = INSTANCE_ID[23:16];
			OFS_ID3:     d = INSTANCE_ID[31:24];
			OFS_STAT_EN: d[BIT_PRESENT] = STATUS_REGS_EN;
			OFS_CTRL_EN: d[BIT_PRESENT] = CONTROL_REGS_EN;
			OFS_MCG_EN:  d[BIT_PRESENT] = MCGB_EN;
			OFS_STATUS:
			begin
				d[BIT_LOCKED]   = pll_locked_i;
				d[BIT_CAL_BUSY] = cal_busy_i;
				d[BIT_BUS_BUSY] = engine_owns_i;
			end
			OFS_PDN:
			begin
				d[BIT_PDN_VAL] = cif.pdn_val;
				d[BIT_PDN_OVR] = cif.pdn_ovr;
			end
			default:     d = 8'h00;
		endcase
		return d;
	endfunction : read_mux

	always_comb
	begin
		st_next            = st_reg;
		st_next.rvalid     = rd_q;
		if (rd_q)
			st_next.rdata = read_mux(addr_i);
		st_next.engine_req = cif.arb_owner;
		st_next.tune_en    = cif.tune_en;
		st_next.recfg_req  = cif.recfg_req;
		st_next.pdn        = cif.pdn_ovr ? cif.pdn_val : pdn_port_i;
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			st_reg <= '{RST_RDATA, 1'b0, RST_ARB_OWNER, RST_TUNE_EN, RST_RECFG_REQ, RST_PDN_VAL};
		else if (clk_en_i)
			st_reg <= st_next;
	end

	assign rdata_o         = st_reg.rdata;
	assign rvalid_o        = st_reg.rvalid;
	assign engine_req_o    = st_reg.engine_req;
	assign tune_enable_o   = st_reg.tune_en;
	assign recfg_req_o     = st_reg.recfg_req;
	assign pll_powerdown_o = st_reg.pdn;

	////////////////////////////////////////////////////////////////////////////
	// checks
	a_arb_write_owner: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(clk_en_i && write_i && addr_i == OFS_ARB) ##1 clk_en_i
		|=> engine_req_o == $past(wdata_i[BIT_ARB_OWNER], 2))
		else $error("arbitration output does not follow written bit");
	a_arb_readback: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_q && addr_i == OFS_ARB) |=> rdata_o[BIT_ARB_OWNER] == $past(cif.arb_owner))
		else $error("arbitration bit reads back wrong");
	a_cal_done_inv: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_q && addr_i == OFS_ARB) |=> rdata_o[BIT_CAL_DONE] == !$past(cal_busy_i))
		else $error("calibration done is not inverse of busy");
	a_tune_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(clk_en_i && write_i && addr_i == OFS_CAL) ##1 clk_en_i
		|=> tune_enable_o == $past(wdata_i[BIT_TUNE_EN], 2))
		else $error("tuning enable does not follow write");
	a_recfg_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(clk_en_i && write_i && addr_i == OFS_CAL) ##1 clk_en_i
		|=> recfg_req_o == $past(wdata_i[BIT_RECFG_REQ], 2))
		else $error("reconfiguration request does not follow write");
	a_cal_readback: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_q && addr_i == OFS_CAL) |=> rdata_o ==
		{6'h00, $past(cif.recfg_req), $past(cif.tune_en)})
		else $error("calibration control reads back wrong");
	a_id_low_byte: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_q && addr_i == OFS_ID0) |=> rdata_o == INSTANCE_ID[7:0])
		else $error("identifier low byte wrong");
	a_id_byte_one: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_q && addr_i == OFS_ID1) |=> rdata_o == INSTANCE_ID[15:8])
		else $error("identifier byte one wrong");
	a_id_byte_two: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_q && addr_i == OFS_ID2) |=> rdata_o == INSTANCE_ID[23:16])
		else $error("identifier byte two wrong");
	a_id_high_byte: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_q && addr_i == OFS_ID3) |=> rdata_o == INSTANCE_ID[31:24])
		else $error("identifier high byte wrong");
	a_stat_present: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_q && addr_i == OFS_STAT_EN) |=> rdata_o == {7'h00, STATUS_REGS_EN})
		else $error("status capability bit wrong");
	a_ctrl_present: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_q && addr_i == OFS_CTRL_EN) |=> rdata_o == {7'h00, CONTROL_REGS_EN})
		else $error("control capability bit wrong");
	a_mcgb_present: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_q && addr_i == OFS_MCG_EN) |=> rdata_o == {7'h00, MCGB_EN})
		else $error("clock generation capability bit wrong");
	a_status_bits: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_q && addr_i == OFS_STATUS) |=> rdata_o[2:0] ==
		{$past(engine_owns_i), $past(cal_busy_i), $past(pll_locked_i)})
		else $error("status register does not show pll state");
	a_pdn_source: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		clk_en_i |=> pll_powerdown_o == ($past(cif.pdn_ovr) ? $past(cif.pdn_val)
		: $past(pdn_port_i)))
		else $error("powerdown source selection wrong");
	a_pdn_readback: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_q && addr_i == OFS_PDN) |=> rdata_o ==
		{6'h00, $past(cif.pdn_ovr), $past(cif.pdn_val)})
		else $error("powerdown control reads back wrong");
	a_rvalid_pulse: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		clk_en_i |=> rvalid_o == $past(rd_q))
		else $error("read answer not one cycle after request");
endmodule : tprb_bank

// ---- verification/tprb_engine_model.sv ----
// behavioural calibration engine and pll facing the register bank
// assumes requests arrive as registered levels on ref_clk_i
`timescale 1ns/1ps
module tprb_engine_model
#(
	parameter int OWN_DLY = 3,
	parameter int CAL_CYC = 20
)
(
	input  wire logic ref_clk_i,
	input  wire logic reset_n_i,
	input  wire logic req_i,
	input  wire logic tune_i,
	input  wire logic pdn_i,
	output logic      owns_o,
	output logic      busy_o,
	output logic      locked_o
);
	logic [7:0] own_sr;
	int         cnt;
	logic       done;
	assign owns_o   = own_sr[OWN_DLY-1];
	assign busy_o   = (cnt != 0);
	assign locked_o = !busy_o && !pdn_i;
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			own_sr <= '0;
			cnt    <= 0;
			done   <= 1'b0;
		end
		else
		begin
			own_sr <= {own_sr[6:0], req_i};
			// calibration needs the bus, so it waits for the handover
			if (tune_i && owns_o && cnt == 0 && !done)
				cnt <= CAL_CYC;
			else if (cnt != 0)
				cnt <= cnt - 1;
			done <= tune_i && (done || cnt == 1);
		end
	end
endmodule : tprb_engine_model

// ---- verification/tprb_bank_test.sv ----
// self-checking bench of the pll register bank driven by strobe read and write tasks
// assumes the engine model answers handover and calibration requests
`timescale 1ns/1ps
module tprb_bank_test;
	import tprb_pkg::*;
	localparam logic [31:0] ID = 32'hC3A5_5A3C; // arbitrary value
	localparam int          CAL_CYC = 20;
	logic              ref_clk_i  = 1'b0;
	logic              reset_n_i  = 1'b0;
	logic              clk_en_i   = 1'b1;
	logic [ADDR_W-1:0] addr_i     = '0;
	logic              write_i    = 1'b0;
	logic              read_i     = 1'b0;
	logic [DATA_W-1:0] wdata_i    = '0;
	logic              pdn_port_i = 1'b0;
	logic [DATA_W-1:0] rdata_o;
	logic              rvalid_o, busy, owns, locked, eng_req, tune_en, recfg, pdn;
	logic [7:0]        v;
	int                err_count = 0;
	int                comparisons = 0;
	initial
	begin
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	tprb_bank #(.INSTANCE_ID(ID), .STATUS_REGS_EN(1'b1), .CONTROL_REGS_EN(1'b0),
		.MCGB_EN(1'b1)) dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i), .addr_i(addr_i), .write_i(write_i), .read_i(read_i),
		.wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .cal_busy_i(busy),
		.engine_owns_i(owns), .pll_locked_i(locked), .pdn_port_i(pdn_port_i),
		.engine_req_o(eng_req), .tune_enable_o(tune_en), .recfg_req_o(recfg),
		.pll_powerdown_o(pdn));
	tprb_engine_model #(.OWN_DLY(3), .CAL_CYC(CAL_CYC)) eng (.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i), .req_i(eng_req), .tune_i(tune_en), .pdn_i(pdn),
		.owns_o(owns), .busy_o(busy), .locked_o(locked));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		write_i <= 1'b1;
		@(posedge ref_clk_i);
		write_i <= 1'b0;
	endtask : wr
	// a missing answer leaves d unknown, so the following compare fails
	task automatic rd(input logic [10:0] a, output logic [7:0] d);
		d = 'x;
		@(posedge ref_clk_i);
		addr_i <= a;
		read_i <= 1'b1;
		@(posedge ref_clk_i);
		read_i <= 1'b0;
		for (int n = 0; n < 4; n++)
		begin
			#1;
			if (rvalid_o === 1'b1)
			begin
				d = rdata_o;
				break;
			end
			@(posedge ref_clk_i);
		end
	endtask : rd
	task automatic rmw(input logic [10:0] a, input logic [7:0] m, input logic [7:0] d);
		logic [7:0] old;
		rd(a, old);
		wr(a, (old & ~m) | (d & m));
	endtask : rmw
	task automatic outs(input logic [3:0] e);
		@(posedge ref_clk_i);
		#1;
		chk({4'h0, eng_req, tune_en, recfg, pdn}, {4'h0, e});
	endtask : outs
	task automatic print_verdict;
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2000) @(posedge ref_clk_i);
		err_count++;
		print_verdict;
	end
	initial
	begin
		repeat (10) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		rd(OFS_ARB, v);
		chk(v, 8'h02);
		rd(OFS_CAL, v);
		chk(v, 8'h00);
		rd(OFS_PDN, v);
		chk(v, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			rd(OFS_ID0 + 11'(i), v);
			chk(v, ID[8*i +: 8]);
		end
		wr(OFS_ID3, 8'h00);
		rd(OFS_ID3, v);
		chk(v, ID[31:24]);
		rd(OFS_STAT_EN, v);
		chk(v, 8'h01);
		rd(OFS_CTRL_EN, v);
		chk(v, 8'h00);
		rd(OFS_MCG_EN, v);
		chk(v, 8'h01);
		rd(11'h7FF, v);
		chk(v, 8'h00);
		@(posedge ref_clk_i);
		pdn_port_i <= 1'b1;
		outs(4'h1);
		rd(OFS_STATUS, v);
		chk(v, 8'h00);
		rmw(OFS_PDN, 8'h03, 8'h02);
		outs(4'h0);
		@(posedge ref_clk_i);
		pdn_port_i <= 1'b0;
		rmw(OFS_PDN, 8'h01, 8'h01);
		outs(4'h1);
		rmw(OFS_PDN, 8'h02, 8'h00);
		outs(4'h0);
		rd(OFS_STATUS, v);
		chk(v, 8'h01);
		rmw(OFS_ARB, 8'h01, 8'h01);
		outs(4'h8);
		repeat (4) @(posedge ref_clk_i);
		rd(OFS_STATUS, v);
		chk(v, 8'h05);
		rmw(OFS_CAL, 8'h03, 8'h03);
		outs(4'hE);
		rd(OFS_STATUS, v);
		chk(v, 8'h06);
		rd(OFS_ARB, v);
		chk(v, 8'h01);
		repeat (CAL_CYC) @(posedge ref_clk_i);
		rd(OFS_ARB, v);
		chk(v, 8'h03);
		rmw(OFS_CAL, 8'h02, 8'h00);
		outs(4'hC);
		rmw(OFS_ARB, 8'h01, 8'h00);
		outs(4'h4);
		repeat (4) @(posedge ref_clk_i);
		rd(OFS_STATUS, v);
		chk(v, 8'h01);
		@(posedge ref_clk_i);
		clk_en_i <= 1'b0;
		wr(OFS_CAL, 8'h00);
		outs(4'h4);
		@(posedge ref_clk_i);
		clk_en_i <= 1'b1;
		rd(OFS_CAL, v);
		chk(v, 8'h01);
		print_verdict;
	end
endmodule : tprb_bank_test
